// File: hdl/rffc_top.sv
// AXI4-Lite register file and top of the receive filter configuration
`timescale 1ns/10ps
module rffc_top
	import rffc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire rffc_frame_t frame,
	output rffc_class_t result,
	output logic [7:0] channel_unicast_enable,
	output logic multicast_accept_enable,
	output logic [2:0] multicast_channel_select
);
	// ****************************************
	// write channel
	// ****************************************
	logic aw_held_q;
	logic w_held_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic wr_fire;
	logic wr_group;
	logic wr_set;
	logic wr_clr;
	logic wr_len;
	logic wr_hit;

	// accept each channel once, hold until response leaves
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready = !w_held_q && !bvalid_q;
	assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
	assign wr_group = wr_fire && awaddr_q[7:2] == RFFC_GROUP_CFG_OFS[7:2];
	assign wr_set = wr_fire && awaddr_q[7:2] == RFFC_UNI_SET_OFS[7:2];
	assign wr_clr = wr_fire && awaddr_q[7:2] == RFFC_UNI_CLR_OFS[7:2];
	assign wr_len = wr_fire && awaddr_q[7:2] == RFFC_MAX_LEN_OFS[7:2];
	assign wr_hit = wr_group || wr_set || wr_clr || wr_len;

	// address and data capture, response generation
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RFFC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? RFFC_RESP_OKAY : RFFC_RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// ****************************************
	// configuration state
	// ****************************************
	logic [7:0] uni_en_q;
	logic [7:0] uni_en_d;
	logic [15:0] max_len_q;
	logic [15:0] max_len_d;
	logic mc_en_q;
	logic [2:0] mc_ch_q;
	logic [7:0] set_mask;
	logic [7:0] clr_mask;

	// byte lane 0 carries the enable bits
	assign set_mask = (wr_set && wstrb_q[0]) ? wdata_q[7:0] : 8'h00;
	assign clr_mask = (wr_clr && wstrb_q[0]) ? wdata_q[7:0] : 8'h00;
	assign uni_en_d = (uni_en_q | set_mask) & ~clr_mask;
	assign max_len_d = {wstrb_q[1] ? wdata_q[15:8] : max_len_q[15:8],
		wstrb_q[0] ? wdata_q[7:0] : max_len_q[7:0]};

	// configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			uni_en_q <= RFFC_UNI_EN_RST;
			max_len_q <= RFFC_MAX_LEN_RST;
			mc_en_q <= RFFC_MC_EN_RST;
			mc_ch_q <= RFFC_MC_CH_RST;
		end else begin
			uni_en_q <= uni_en_d;
			if (wr_len) begin
				max_len_q <= max_len_d;
			end
			if (wr_group && wstrb_q[0]) begin
				mc_ch_q <= wdata_q[RFFC_MC_CH_MSB:RFFC_MC_CH_LSB];
				mc_en_q <= wdata_q[RFFC_MC_EN_BIT];
			end
		end
	end
	assign channel_unicast_enable = uni_en_q;
	assign multicast_accept_enable = mc_en_q;
	assign multicast_channel_select = mc_ch_q;

	// ****************************************
	// read channel
	// ****************************************
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [31:0] rd_group;
	logic [31:0] rd_word;
	logic rd_hit;
	logic [5:0] rd_idx;

	assign s_axi_arready = !rvalid_q;
	assign rd_idx = s_axi_araddr[7:2];
	assign rd_group = {26'h0, mc_en_q, 2'h0, mc_ch_q};
	assign rd_hit = rd_idx == RFFC_GROUP_CFG_OFS[7:2] ||
		rd_idx == RFFC_UNI_SET_OFS[7:2] ||
		rd_idx == RFFC_UNI_CLR_OFS[7:2] ||
		rd_idx == RFFC_MAX_LEN_OFS[7:2];
	assign rd_word =
		(rd_idx == RFFC_GROUP_CFG_OFS[7:2]) ? rd_group :
		(rd_idx == RFFC_UNI_SET_OFS[7:2]) ? {24'h0, uni_en_q} :
		(rd_idx == RFFC_UNI_CLR_OFS[7:2]) ? {24'h0, uni_en_q} :
		(rd_idx == RFFC_MAX_LEN_OFS[7:2]) ? {16'h0, max_len_q} :
		32'h0000_0000;

	// read data register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RFFC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_hit ? RFFC_RESP_OKAY : RFFC_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// ****************************************
	// classifier
	// ****************************************
	rffc_classify u_classify (
		.aclk(aclk),
		.aresetn(aresetn),
		.frame(frame),
		.max_frame_length(max_len_q),
		.multicast_accept_enable(mc_en_q),
		.multicast_channel_select(mc_ch_q),
		.result(result)
	);

	uni_set_a: assert property (@(posedge aclk)
		disable iff (!aresetn)
		wr_set && wstrb_q[0] && !wr_clr
		|=> (uni_en_q & $past(wdata_q[7:0])) == $past(wdata_q[7:0]))
		else $error("set did not stick");
	uni_clr_a: assert property (@(posedge aclk)
		disable iff (!aresetn)
		wr_clr && wstrb_q[0]
		|=> (uni_en_q & $past(wdata_q[7:0])) == 8'h00)
		else $error("clear did not act");
	uni_hold_a: assert property (@(posedge aclk)
		disable iff (!aresetn)
		!wr_set && !wr_clr |=> $stable(uni_en_q))
		else $error("enables moved without write");
	len_wr_a: assert property (@(posedge aclk)
		disable iff (!aresetn)
		wr_len && wstrb_q == 4'hf |=> max_len_q == $past(wdata_q[15:0]))
		else $error("length write lost");
	mc_ch_wr_a: assert property (@(posedge aclk)
		disable iff (!aresetn)
		wr_group && wstrb_q[0] |=> mc_ch_q == $past(wdata_q[2:0]))
		else $error("channel write lost");
endmodule

// File: hdl/rffc_pkg.sv
// package of constants and types for the receive filter configuration block
package rffc_pkg;
	// register byte offsets
	localparam logic [7:0] RFFC_GROUP_CFG_OFS = 8'h00;
	localparam logic [7:0] RFFC_UNI_SET_OFS = 8'h04;
	localparam logic [7:0] RFFC_UNI_CLR_OFS = 8'h08;
	localparam logic [7:0] RFFC_MAX_LEN_OFS = 8'h0c;
	// field positions
	localparam int RFFC_MC_CH_LSB = 0;
	localparam int RFFC_MC_CH_MSB = 2;
	localparam int RFFC_MC_EN_BIT = 5;
	// reset values
	localparam logic [15:0] RFFC_MAX_LEN_RST = 16'h05ee;
	localparam logic [7:0] RFFC_UNI_EN_RST = 8'h00;
	localparam logic [2:0] RFFC_MC_CH_RST = 3'h0;
	localparam logic RFFC_MC_EN_RST = 1'b0;
	// AXI response codes
	localparam logic [1:0] RFFC_RESP_OKAY = 2'h0;
	localparam logic [1:0] RFFC_RESP_SLVERR = 2'h2;

	// frame report from the receive path
	typedef struct packed {
		logic valid;
		logic [15:0] byte_count;
		logic crc_err;
		logic code_err;
		logic align_err;
		logic multicast_hit;
	} rffc_frame_t;

	// classification result
	typedef struct packed {
		logic valid;
		logic long_frame;
		logic oversized;
		logic jabber;
		logic mc_deliver;
		logic mc_drop;
		logic [2:0] mc_channel;
	} rffc_class_t;
endpackage

// File: hdl/rffc_classify.sv
// frame length classifier and multicast steering
`timescale 1ns/10ps
module rffc_classify
	import rffc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire rffc_frame_t frame,
	input wire logic [15:0] max_frame_length,
	input wire logic multicast_accept_enable,
	input wire logic [2:0] multicast_channel_select,
	output rffc_class_t result
);
	logic is_long;
	logic any_err;
	rffc_class_t result_d;
	rffc_class_t result_q;

	assign is_long = frame.byte_count > max_frame_length;
	assign any_err = frame.crc_err | frame.code_err | frame.align_err;

	// build the result word
	always_comb begin
		result_d = '0;
		result_d.valid = frame.valid;
		result_d.long_frame = frame.valid & is_long;
		result_d.oversized = frame.valid & is_long & ~any_err;
		result_d.jabber = frame.valid & is_long & any_err;
		result_d.mc_deliver = frame.valid & frame.multicast_hit &
			multicast_accept_enable;
		result_d.mc_drop = frame.valid & frame.multicast_hit &
			~multicast_accept_enable;
		result_d.mc_channel = multicast_channel_select;
	end

	// register the result
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_q <= '0;
		end else begin
			result_q <= result_d;
		end
	end
	assign result = result_q;

	long_cls_a: assert property (@(posedge aclk)
		disable iff (!aresetn)
		frame.valid |=> result.long_frame ==
		($past(frame.byte_count) > $past(max_frame_length)))
		else $error("long flag mismatch");
	oversize_cls_a: assert property (@(posedge aclk)
		disable iff (!aresetn)
		result.oversized |-> result.long_frame && !result.jabber)
		else $error("oversized without long");
	jabber_cls_a: assert property (@(posedge aclk)
		disable iff (!aresetn)
		frame.valid && (frame.byte_count > max_frame_length) &&
		(frame.crc_err || frame.code_err || frame.align_err)
		|=> result.jabber)
		else $error("jabber missed");
	mc_drop_a: assert property (@(posedge aclk)
		disable iff (!aresetn)
		frame.valid && frame.multicast_hit && !multicast_accept_enable
		|=> result.mc_drop && !result.mc_deliver)
		else $error("multicast not dropped");
endmodule

// File: tb/rffc_top_tb.sv
// self-checking bench for the receive filter configuration block
`timescale 1ns/10ps
module rffc_top_tb
	import rffc_pkg::*;
;
	typedef struct packed {
		logic [15:0] max;
		logic [15:0] cnt;
		logic [2:0] err;
		logic hit;
		logic en;
		logic [2:0] ch;
		logic lng;
	} rffc_row_t;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, multicast_accept_enable;
	logic [7:0] channel_unicast_enable;
	logic [2:0] multicast_channel_select;
	rffc_frame_t frame;
	rffc_class_t result;
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	// length cases: equal, one above, each error kind, steering
	rffc_row_t rows [7] = '{
		'{16'h05ee, 16'h05ee, 3'h0, 1'b0, 1'b0, 3'h0, 1'b0},
		'{16'h05ee, 16'h05ef, 3'h0, 1'b0, 1'b0, 3'h0, 1'b1},
		'{16'h05ee, 16'h05ef, 3'h4, 1'b0, 1'b0, 3'h0, 1'b1},
		'{16'h05ee, 16'h0600, 3'h2, 1'b1, 1'b0, 3'h2, 1'b1},
		'{16'h0040, 16'h0041, 3'h1, 1'b1, 1'b1, 3'h5, 1'b1},
		'{16'hffff, 16'hffff, 3'h7, 1'b1, 1'b0, 3'h3, 1'b0},
		'{16'h0000, 16'h0001, 3'h0, 1'b0, 1'b1, 3'h6, 1'b1}};

	rffc_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frame, .result,
		.channel_unicast_enable, .multicast_accept_enable,
		.multicast_channel_select);

	// ****************************************
	// clock, timeout and shared tasks
	// ****************************************
	always #25 aclk = ~aclk;

	// hang guard, the run needs a few hundred cycles
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			complete_run();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// write; address and data offered together, each dropped when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		logic pa, pw, ra, rw, b;
		logic [1:0] r;
		pa = 1'b1;
		pw = 1'b1;
		b = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (pa || pw) begin
			@(negedge aclk);
			ra = s_axi_awready;
			rw = s_axi_wready;
			@(posedge aclk);
			if (pa && ra) begin
				s_axi_awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (pw && rw) begin
				s_axi_wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		while (!b) begin
			@(negedge aclk);
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
		end
		s_axi_bready <= 1'b0;
		chk(r, er);
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic g, v;
		logic [31:0] d;
		logic [1:0] r;
		g = 1'b0;
		v = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!g) begin
			@(negedge aclk);
			g = s_axi_arready;
			@(posedge aclk);
		end
		s_axi_arvalid <= 1'b0;
		while (!v) begin
			@(negedge aclk);
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
		end
		s_axi_rready <= 1'b0;
		chk(d, ed);
		chk(r, er);
		@(posedge aclk);
	endtask

	// program length and steering, send one frame, judge the report
	task automatic cfg_frm(input rffc_row_t w);
		rffc_class_t e;
		axi_wr(RFFC_MAX_LEN_OFS, {16'h0, w.max}, 4'hf,
			RFFC_RESP_OKAY);
		axi_wr(RFFC_GROUP_CFG_OFS, {26'h0, w.en, 2'h0, w.ch}, 4'hf,
			RFFC_RESP_OKAY);
		e.valid = 1'b1;
		e.long_frame = w.lng;
		e.oversized = w.lng && w.err == 3'h0;
		e.jabber = w.lng && w.err != 3'h0;
		e.mc_deliver = w.hit && w.en;
		e.mc_drop = w.hit && !w.en;
		e.mc_channel = w.ch;
		chk(multicast_channel_select, w.ch);
		chk(multicast_accept_enable, w.en);
		frame <= '{1'b1, w.cnt, w.err[2], w.err[1], w.err[0], w.hit};
		@(posedge aclk);
		frame <= '0;
		@(negedge aclk);
		chk(result, e);
		@(posedge aclk);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		frame = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(channel_unicast_enable, 8'h00);
		// ordinary cases from the table
		foreach (rows[i])
			cfg_frm(rows[i]);
		// mid-run resets undo the table's length and steering
		for (int k = 0; k < 2; k++) begin
			aresetn <= 1'b0;
			repeat (20) @(posedge aclk);
			aresetn <= 1'b1;
			@(posedge aclk);
			chk(channel_unicast_enable, 8'h00);
			axi_rd(RFFC_UNI_SET_OFS, 32'h0, RFFC_RESP_OKAY);
			axi_rd(RFFC_MAX_LEN_OFS, 32'h5ee, RFFC_RESP_OKAY);
			axi_rd(RFFC_GROUP_CFG_OFS, 32'h0, RFFC_RESP_OKAY);
			axi_wr(RFFC_UNI_SET_OFS, 32'hffffff81, 4'hf,
				RFFC_RESP_OKAY);
			chk(channel_unicast_enable, 8'h81);
		end
		axi_wr(RFFC_UNI_SET_OFS, 32'h02, 4'hf, RFFC_RESP_OKAY);
		axi_wr(RFFC_UNI_CLR_OFS, 32'h01, 4'hf, RFFC_RESP_OKAY);
		chk(channel_unicast_enable, 8'h82);
		axi_rd(RFFC_UNI_CLR_OFS, 32'h82, RFFC_RESP_OKAY);
		axi_rd(RFFC_UNI_SET_OFS, 32'h82, RFFC_RESP_OKAY);
		axi_wr(RFFC_UNI_CLR_OFS, 32'h0, 4'hf, RFFC_RESP_OKAY);
		chk(channel_unicast_enable, 8'h82);
		axi_wr(RFFC_UNI_CLR_OFS, 32'hff, 4'hf, RFFC_RESP_OKAY);
		chk(channel_unicast_enable, 8'h00);
		// low byte lane only, upper length bits kept
		axi_wr(RFFC_MAX_LEN_OFS, 32'hffff1234, 4'h1,
			RFFC_RESP_OKAY);
		axi_rd(RFFC_MAX_LEN_OFS, 32'h0534, RFFC_RESP_OKAY);
		// unmapped place refused with no effect
		axi_wr(8'h10, 32'hffffffff, 4'hf, RFFC_RESP_SLVERR);
		axi_rd(8'h10, 32'h0, RFFC_RESP_SLVERR);
		axi_rd(RFFC_MAX_LEN_OFS, 32'h0534, RFFC_RESP_OKAY);
		for (int c = 0; c < 8; c++) begin
			cfg_frm('{16'h05ee, 16'h0040, 3'h0, 1'b1, 1'b1, c[2:0],
				1'b0});
			axi_rd(RFFC_GROUP_CFG_OFS, {26'h0, 1'b1, 2'h0, c[2:0]},
				RFFC_RESP_OKAY);
		end
		complete_run();
	end
endmodule
